// *** rtl/prot_pkg.sv ***
// package of constants and carriers for the program memory protection controller
`default_nettype none
package prot_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   // register indices; byte address is four times the index
   localparam logic [7:0] CTL_INDEX = 8'h2f;
   localparam logic [7:0] OPTION_INDEX = 8'h40;
   localparam logic [7:0] STATUS_INDEX = 8'h41;
   localparam logic [ADDR_W-1:0] CTL_ADDR = {2'h0, CTL_INDEX, 2'h0};
   localparam logic [ADDR_W-1:0] OPTION_ADDR = {2'h0, OPTION_INDEX, 2'h0};
   localparam logic [ADDR_W-1:0] STATUS_ADDR = {2'h0, STATUS_INDEX, 2'h0};
   // unlock keys
   localparam logic [7:0] FIRST_KEY = 8'h56;
   localparam logic [7:0] SECOND_KEY = 8'hae;
   // flash_control_status fields
   localparam int unsigned START_BIT = 0;
   localparam int unsigned LATCH_BIT = 1;
   localparam int unsigned AREA_BIT = 2;
   localparam int unsigned CTL_W = 3;
   localparam logic [CTL_W-1:0] CTL_RESET = 3'h0;
   // option register fields
   localparam int unsigned ROP_BIT = 0;
   localparam int unsigned WP_BIT = 1;
   // status register fields
   localparam int unsigned ST_OPEN_BIT = 0;
   localparam int unsigned ST_ERASE_BIT = 1;
   localparam int unsigned ST_ROP_BIT = 2;
   localparam int unsigned ST_WP_BIT = 3;
   localparam int unsigned ST_REFUSED_BIT = 4;
   // mass erase duration in pclk cycles
   localparam logic [7:0] ERASE_CYCLES = 8'h10;
   localparam logic [7:0] ERASE_LAST = 8'h01;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   typedef enum logic [2:0] {
      KEY_LOCKED = 3'b001,
      KEY_FIRST = 3'b010,
      KEY_OPEN = 3'b100
   } key_state_t;

   typedef struct packed {
      logic write_protect_option;
      logic readout_protect_option;
   } option_t;

   typedef struct packed {
      logic flash_prog_req;
      logic flash_write_en;
      logic data_write_en;
      logic latch_select;
      logic ext_read_block;
      logic mass_erase;
      logic opt_store_valid;
      option_t opt_store;
   } mem_ctrl_t;

   typedef struct packed {
      key_state_t key;
      logic [CTL_W-1:0] ctl;
      option_t option_area_select;
      option_t sync_a;
      option_t sync_b;
      logic [1:0] warm;
      logic opt_loaded;
      logic erasing;
      logic [7:0] erase_cnt;
      logic prog_req;
      logic refused;
      logic store_valid;
      logic [DATA_W-1:0] rdata;
      logic slverr;
   } state_t;
endpackage : prot_pkg
`default_nettype wire

// *** rtl/program_memory_protection_ctrl.sv ***
// protection and programming control for program flash and data nonvolatile memory
`default_nettype none

// Functional notes
// - read-out and write protection are independent
// - read-out protection blocks extraction and flash writes
// - read-out protection covers flash and data memory
// - removing read-out protection erases both memories
// - read-out protection set only by option bit
// - write protection blocks flash, data stays writable
// - write protection can never be cleared
// - write protection set only by option bit
// - control register resets zero, upper bits zero
// - control register serves programming methods only
module program_memory_protection_ctrl
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [prot_pkg::ADDR_W-1:0] paddr,
   input wire logic [prot_pkg::DATA_W-1:0] pwdata,
   output logic [prot_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire prot_pkg::option_t opt_byte_in,
   output prot_pkg::mem_ctrl_t mem_ctrl
);
   import prot_pkg::*;

   state_t s_reg;
   state_t s_next;
   logic setup_phase;
   logic wr_access;
   logic wr_ctl;
   logic wr_option;
   logic wr_status;
   logic load_now;
   logic opt_accept;
   logic flash_ok;
   logic [7:0] wbyte;

   // apb phase decode; the slave answers in the first access cycle
   assign setup_phase = psel & ~penable;
   assign wr_access = psel & penable & pwrite;
   assign wr_ctl = wr_access & (paddr == CTL_ADDR);
   assign wr_option = wr_access & (paddr == OPTION_ADDR);
   assign wr_status = wr_access & (paddr == STATUS_ADDR);
   assign wbyte = pwdata[7:0];

   // option byte is taken once the pin synchroniser has filled after reset
   assign load_now = s_reg.warm[1] & ~s_reg.opt_loaded;

   // option rewrites need the open key state and the option area selected
   assign opt_accept = (s_reg.key == KEY_OPEN) & s_reg.ctl[AREA_BIT] & ~s_reg.erasing;

   // flash program and erase gated by both protections
   assign flash_ok = (s_reg.key == KEY_OPEN) & ~s_reg.option_area_select.readout_protect_option
                     & ~s_reg.option_area_select.write_protect_option & ~s_reg.erasing;

   // next-state logic
   always_comb
   begin
      s_next = s_reg;
      s_next.prog_req = 1'b0;
      s_next.store_valid = 1'b0;
      // two-stage synchroniser for the option byte pins
      s_next.sync_a = opt_byte_in;
      s_next.sync_b = s_reg.sync_a;
      s_next.warm = {s_reg.warm[0], 1'b1};

      // protection state comes from the option byte
      if (load_now)
      begin
         s_next.option_area_select = s_reg.sync_b;
         s_next.opt_loaded = 1'b1;
      end

      // read data and error are prepared in the setup cycle
      if (setup_phase)
      begin
         s_next.slverr = 1'b0;
         s_next.rdata = ZERO_WORD;
         case (paddr)
            // bits 31 to 3 always read zero
            CTL_ADDR:
            begin
               s_next.rdata[CTL_W-1:0] = s_reg.ctl;
            end
            OPTION_ADDR:
            begin
               s_next.rdata[ROP_BIT] = s_reg.option_area_select.readout_protect_option;
               s_next.rdata[WP_BIT] = s_reg.option_area_select.write_protect_option;
            end
            STATUS_ADDR:
            begin
               s_next.rdata[ST_OPEN_BIT] = (s_reg.key == KEY_OPEN);
               s_next.rdata[ST_ERASE_BIT] = s_reg.erasing;
               s_next.rdata[ST_ROP_BIT] = s_reg.option_area_select.readout_protect_option;
               s_next.rdata[ST_WP_BIT] = s_reg.option_area_select.write_protect_option;
               s_next.rdata[ST_REFUSED_BIT] = s_reg.refused;
            end
            default:
            begin
               s_next.slverr = 1'b1;
            end
         endcase
      end

      // refused flag is write-one-to-clear; later sets override this
      if (wr_status && pwdata[ST_REFUSED_BIT])
      begin
         s_next.refused = 1'b0;
      end

      // key sequence; any write between the keys relocks
      case (s_reg.key)
         KEY_LOCKED:
         begin
            if (wr_ctl && (wbyte == FIRST_KEY))
            begin
               s_next.key = KEY_FIRST;
            end
         end
         KEY_FIRST:
         begin
            if (wr_ctl && (wbyte == SECOND_KEY))
            begin
               s_next.key = KEY_OPEN;
            end
            else if (wr_access)
            begin
               s_next.key = KEY_LOCKED;
            end
         end
         KEY_OPEN:
         begin
            // control bits only writable once programming access is open
            if (wr_ctl)
            begin
               s_next.ctl = wbyte[CTL_W-1:0];
               if (wbyte[START_BIT])
               begin
                  // program start refused under either protection
                  if (flash_ok)
                  begin
                     s_next.prog_req = 1'b1;
                  end
                  else
                  begin
                     s_next.refused = 1'b1;
                  end
               end
            end
         end
         default:
         begin
            s_next.key = KEY_LOCKED;
         end
      endcase

      // option rewrite through the register
      if (wr_option)
      begin
         if (opt_accept)
         begin
            // write protection only ever gets set
            s_next.option_area_select.write_protect_option = s_reg.option_area_select.write_protect_option | pwdata[WP_BIT];
            // read-out field handled apart from write protection
            if (s_reg.option_area_select.readout_protect_option && !pwdata[ROP_BIT])
            begin
               // removal starts a mass erase before the bit clears
               s_next.erasing = 1'b1;
               s_next.erase_cnt = ERASE_CYCLES;
            end
            else
            begin
               // read-out protection enabled by its option bit
               s_next.option_area_select.readout_protect_option = pwdata[ROP_BIT];
            end
            s_next.store_valid = 1'b1;
         end
         else
         begin
            s_next.refused = 1'b1;
         end
      end

      // erase both memories, then drop read-out protection
      if (s_reg.erasing)
      begin
         if (s_reg.erase_cnt == ERASE_LAST)
         begin
            s_next.erasing = 1'b0;
            s_next.option_area_select.readout_protect_option = 1'b0;
            s_next.store_valid = 1'b1;
         end
         s_next.erase_cnt = s_reg.erase_cnt - ERASE_LAST;
      end
   end

   // state register, constants only under reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg <= '0;
         s_reg.key <= KEY_LOCKED;
         s_reg.ctl <= CTL_RESET;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // apb answer
   assign prdata = s_reg.rdata;
   assign pready = psel & penable;
   assign pslverr = psel & penable & s_reg.slverr;

   // memory side controls
   always_comb
   begin
      mem_ctrl.flash_prog_req = s_reg.prog_req;
      mem_ctrl.flash_write_en = flash_ok;
      mem_ctrl.data_write_en = (s_reg.key == KEY_OPEN) & ~s_reg.erasing;
      mem_ctrl.latch_select = s_reg.ctl[LATCH_BIT];
      // extraction blocked for both arrays, also during erase
      mem_ctrl.ext_read_block = s_reg.option_area_select.readout_protect_option | s_reg.erasing;
      mem_ctrl.mass_erase = s_reg.erasing;
      mem_ctrl.opt_store_valid = s_reg.store_valid;
      mem_ctrl.opt_store = s_reg.option_area_select;
   end

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_wp_never_clears: assert property (s_reg.option_area_select.write_protect_option |=> s_reg.option_area_select.write_protect_option)
      else $error("write protection cleared");

   a_ctl_upper_zero: assert property ((setup_phase && paddr == CTL_ADDR) |=> prdata[31:3] == 29'h0)
      else $error("flash control upper bits not zero");

   a_open_after_first: assert property ($rose(s_reg.key == KEY_OPEN) |-> $past(s_reg.key) == KEY_FIRST)
      else $error("unlock without first key");

   a_first_then_other: assert property ((s_reg.key == KEY_FIRST && wr_access
      && !(wr_ctl && wbyte == SECOND_KEY)) |=> s_reg.key == KEY_LOCKED)
      else $error("wrong key order did not relock");

   a_locked_ctl_hold: assert property ((s_reg.key != KEY_OPEN && wr_ctl) |=> $stable(s_reg.ctl))
      else $error("locked control register changed");

   a_prog_needs_free: assert property (mem_ctrl.flash_prog_req |-> $past(s_reg.key) == KEY_OPEN
      && !$past(s_reg.option_area_select.readout_protect_option) && !$past(s_reg.option_area_select.write_protect_option))
      else $error("program start under protection");

   a_rop_blocks_flash: assert property (s_reg.option_area_select.readout_protect_option |-> !mem_ctrl.flash_write_en
      && mem_ctrl.ext_read_block)
      else $error("read-out protection not applied");

   a_wp_blocks_flash: assert property (s_reg.option_area_select.write_protect_option |-> !mem_ctrl.flash_write_en)
      else $error("write protection not applied");

   a_locked_no_access: assert property (s_reg.key != KEY_OPEN |-> !mem_ctrl.flash_write_en
      && !mem_ctrl.data_write_en)
      else $error("write enable while locked");

   a_erase_length: assert property ($rose(s_reg.erasing) |-> s_reg.erasing[*8] ##9 !s_reg.erasing)
      else $error("mass erase length wrong");

   a_erase_clears_rop: assert property ($fell(s_reg.erasing) |-> !s_reg.option_area_select.readout_protect_option
      && mem_ctrl.opt_store_valid)
      else $error("read-out protection kept after erase");

   a_rop_rise_cause: assert property ($rose(s_reg.option_area_select.readout_protect_option) |-> $past(wr_option)
      || $past(load_now))
      else $error("read-out protection set without option");

   a_wp_rise_cause: assert property ($rose(s_reg.option_area_select.write_protect_option) |-> $past(wr_option)
      || $past(load_now))
      else $error("write protection set without option");

   // further checks on pulses, refusals and the answer path; each guards a hazard a scenario can miss
   // a second pulse would start a second program cycle in the array
   a_prog_one_pulse: assert property (mem_ctrl.flash_prog_req |=> !mem_ctrl.flash_prog_req)
      else $error("program start longer than one cycle");

   a_refused_sets: assert property ((wr_option && !opt_accept) |=> s_reg.refused)
      else $error("refused option write not flagged");

   // neither array may be written while the mass erase runs
   a_erase_blocks_we: assert property (s_reg.erasing |-> !mem_ctrl.flash_write_en && !mem_ctrl.data_write_en)
      else $error("write enable during mass erase");

   a_unmapped_error: assert property ((setup_phase && paddr != CTL_ADDR && paddr != OPTION_ADDR
      && paddr != STATUS_ADDR) |=> s_reg.slverr && prdata == ZERO_WORD)
      else $error("unmapped access not answered with error");

   // unlock is held until reset; no relock command exists
   a_open_stays: assert property (s_reg.key == KEY_OPEN |=> s_reg.key == KEY_OPEN)
      else $error("programming access lost");

   a_ctl_reads_back: assert property ((setup_phase && paddr == CTL_ADDR)
      |=> prdata[CTL_W-1:0] == $past(s_reg.ctl))
      else $error("control register read back wrong");

   a_store_follows_opt: assert property ((wr_option && opt_accept) |=> mem_ctrl.opt_store_valid)
      else $error("accepted option not handed to store");

   // read-out protection may only drop at the end of an erase
   a_rop_fall_erase: assert property ($fell(s_reg.option_area_select.readout_protect_option) |-> $past(s_reg.erasing))
      else $error("read-out protection dropped without erase");

   a_load_once: assert property (load_now |=> s_reg.opt_loaded)
      else $error("option byte not taken");

   a_data_ignores_wp: assert property ((s_reg.key == KEY_OPEN && !s_reg.erasing
      && s_reg.option_area_select.write_protect_option) |-> mem_ctrl.data_write_en)
      else $error("data memory blocked by write protection");

   a_locked_ctl_zero: assert property (s_reg.key != KEY_OPEN |-> s_reg.ctl == CTL_RESET)
      else $error("control bits set while locked");

   c_unlock: cover property (s_reg.key == KEY_FIRST ##1 s_reg.key == KEY_OPEN);
   c_program: cover property (mem_ctrl.flash_prog_req);
   c_erase_done: cover property ($fell(s_reg.erasing));
   c_refused: cover property ($rose(s_reg.refused));
   c_reload: cover property ($rose(s_reg.opt_loaded));
endmodule : program_memory_protection_ctrl
`default_nettype wire

// *** bench/prog_tool.sv ***
// programming tool model: apb master that sends transfers and the unlock keys
`default_nettype none
module prog_tool
(
   input wire logic pclk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [prot_pkg::DATA_W-1:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [prot_pkg::ADDR_W-1:0] paddr,
   output logic [prot_pkg::DATA_W-1:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import prot_pkg::*;

   // idle bus at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end

   // one apb transfer; released lines show the inverse so stale data never matches
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer

   task automatic unlock();
      logic [DATA_W-1:0] r;
      logic e;
      xfer(1'b1, CTL_ADDR, {24'h0, FIRST_KEY}, r, e);
      xfer(1'b1, CTL_ADDR, {24'h0, SECOND_KEY}, r, e);
   endtask : unlock
endmodule : prog_tool
`default_nettype wire

// *** bench/program_memory_protection_ctrl_tb.sv ***
// self-checking bench for the program memory protection controller
`default_nettype none
module program_memory_protection_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import prot_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   option_t opt_pins = '0;
   mem_ctrl_t mc;
   int fail_count = 0;
   int num_checks = 0;

   // 250 MHz clock
   always #2 pclk = ~pclk;

   program_memory_protection_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .opt_byte_in(opt_pins), .mem_ctrl(mc));

   prog_tool tool (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   // compare and count
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
         fail_count++;
      end
   endtask : check

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      tool.xfer(1'b1, a, {24'h0, d}, r, e);
   endtask : wr

   task automatic rd(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] x);
      logic [31:0] r;
      logic e;
      tool.xfer(1'b0, a, '0, r, e);
      check(nm, r, {24'h0, x});
   endtask : rd

   // callers sample at a falling edge so flops have settled
   task automatic flag(input string nm, input logic seen, input logic x);
      check(nm, {31'h0, seen}, {31'h0, x});
   endtask : flag

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude

   task automatic test_reset();
      rd("ctl", CTL_ADDR, 8'h00);
      rd("status", STATUS_ADDR, 8'h00);
      @(negedge pclk);
      check("mem_ctrl", {23'h0, mc}, 32'h0);
      $display("test_reset done");
   endtask : test_reset

   // wrong key orders and a broken pair must leave the register locked
   task automatic test_lock();
      wr(CTL_ADDR, SECOND_KEY);
      wr(CTL_ADDR, FIRST_KEY);
      wr(STATUS_ADDR, 8'h00);
      wr(CTL_ADDR, SECOND_KEY);
      rd("locked", STATUS_ADDR, 8'h00);
      rd("ctl_locked", CTL_ADDR, 8'h00);
      wr(OPTION_ADDR, 8'h01);
      rd("opt_refused", STATUS_ADDR, 8'h10);
      wr(STATUS_ADDR, 8'h10);
      rd("refused_clr", STATUS_ADDR, 8'h00);
      $display("test_lock done");
   endtask : test_lock

   task automatic test_unlock();
      tool.unlock();
      rd("open", STATUS_ADDR, 8'h01);
      wr(CTL_ADDR, 8'hff);
      @(negedge pclk);
      flag("prog_req", mc.flash_prog_req, 1'b1);
      flag("fwe", mc.flash_write_en, 1'b1);
      flag("latch", mc.latch_select, 1'b1);
      @(negedge pclk);
      flag("prog_end", mc.flash_prog_req, 1'b0);
      rd("ctl_bits", CTL_ADDR, 8'h07);
      $display("test_unlock done");
   endtask : test_unlock

   // read-out protection on, refused program start, then removal with mass erase
   task automatic test_readout();
      int n = 0;
      wr(OPTION_ADDR, 8'h01);
      rd("rop_on", STATUS_ADDR, 8'h05);
      @(negedge pclk);
      flag("rd_block", mc.ext_read_block, 1'b1);
      flag("fwe_rop", mc.flash_write_en, 1'b0);
      flag("dwe_rop", mc.data_write_en, 1'b1);
      wr(CTL_ADDR, 8'h07);
      @(negedge pclk);
      flag("no_prog", mc.flash_prog_req, 1'b0);
      rd("prog_refused", STATUS_ADDR, 8'h15);
      wr(STATUS_ADDR, 8'h10);
      wr(OPTION_ADDR, 8'h00);
      repeat (40)
      begin
         @(negedge pclk);
         if (mc.mass_erase === 1'b1)
            n++;
      end
      check("erase_len", n, {24'h0, ERASE_CYCLES});
      rd("rop_off", STATUS_ADDR, 8'h01);
      $display("test_readout done");
   endtask : test_readout

   task automatic test_wprot();
      wr(OPTION_ADDR, 8'h02);
      rd("wp_on", STATUS_ADDR, 8'h09);
      @(negedge pclk);
      flag("fwe_wp", mc.flash_write_en, 1'b0);
      flag("dwe_wp", mc.data_write_en, 1'b1);
      wr(OPTION_ADDR, 8'h00);
      rd("wp_kept", STATUS_ADDR, 8'h09);
      wr(OPTION_ADDR, 8'h01);
      rd("both", STATUS_ADDR, 8'h0d);
      $display("test_wprot done");
   endtask : test_wprot

   task automatic test_unmapped();
      logic [31:0] r;
      logic e;
      tool.xfer(1'b0, 12'h200, '0, r, e);
      check("slverr", {31'h0, e}, 32'h1);
      check("unmapped", r, 32'h0);
      $display("test_unmapped done");
   endtask : test_unmapped

   // reset in mid-run with both option pins high: options load three edges after release
   task automatic test_pins();
      @(posedge pclk);
      presetn <= 1'b0;
      opt_pins <= '{write_protect_option: 1'b1, readout_protect_option: 1'b1};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd("pins_early", STATUS_ADDR, 8'h00);
      rd("pins_loaded", STATUS_ADDR, 8'h0c);
      rd("ctl_after_reset", CTL_ADDR, 8'h00);
      @(negedge pclk);
      flag("rd_block_pins", mc.ext_read_block, 1'b1);
      flag("fwe_pins", mc.flash_write_en, 1'b0);
      $display("test_pins done");
   endtask : test_pins

   // reset, then the scenarios in order
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      test_reset();
      test_lock();
      test_unlock();
      test_readout();
      test_wprot();
      test_unmapped();
      test_pins();
      conclude();
   end

   // watchdog well beyond the fewer than two hundred cycles the run needs
   initial
   begin
      repeat (5000) @(posedge pclk);
      fail_count++;
      conclude();
   end
endmodule : program_memory_protection_ctrl_tb
`default_nettype wire
